// [common/hv_sync_regs.svh]
// register offsets, field positions, reset values and timing counts for the sync processor
`ifndef HV_SYNC_REGS_SVH
`define HV_SYNC_REGS_SVH
`define SYNC_INPUT_CONTROL_ADDR   4'h6
`define SYNC_IO_CONTROL_ADDR      4'h7
`define HCOUNT_LO_ADDR            4'h8
`define HCOUNT_HI_ADDR            4'h9
`define VCOUNT_LO_ADDR            4'hA
`define VCOUNT_HI_ADDR            4'hB
`define FREE_RUN_CONTROL_ADDR     4'hC
`define HALF_FREQ_CONTROL_ADDR    4'hD
`define CTRL_RESET                8'hFF
`define OVF_CLEAR_BIT             7
`define CLK_HZ                    8000000
`define GLITCH_NS                 125
`define GLITCH_CYCLES             (((`GLITCH_NS * (`CLK_HZ / 1000000)) + 999) / 1000)
`define TICK_US                   8
`define TICK_CYCLES               (`TICK_US * (`CLK_HZ / 1000000))
`define WIN0_US                   16384
`define WIN0_TICKS                (`WIN0_US / `TICK_US)
`define INSERT_US                 2
`define INSERT_CYCLES             (`INSERT_US * (`CLK_HZ / 1000000))
`define VWIDEN_US                 9
`define VWIDEN_CYCLES             (`VWIDEN_US * (`CLK_HZ / 1000000))
`define SAMPLE_CYCLES             4096
`endif

// [common/hv_sync_pkg.sv]
// types shared by the sync processor modules
package hv_sync_pkg;
  typedef enum logic [2:0] {
    fr_idle  = 3'b001,
    fr_pulse = 3'b010,
    fr_gap   = 3'b100
  } free_run_state_t;
  typedef struct packed {
    logic [7:0] h_div;
    logic [3:0] h_pre;
    logic [10:0] v_div;
    logic        active;
  } free_run_cfg_t;
endpackage : hv_sync_pkg

// [common/sync_filter_if.sv]
// carrier between the sync processor and its input filter
`timescale 1ns/100ps
interface sync_filter_if;
  logic raw;
  logic clean;
  logic rise;
  logic fall;
  modport filter (input raw, output clean, output rise, output fall);
  modport user   (output raw, input clean, input rise, input fall);
endinterface : sync_filter_if

// [hdl/sync_glitch_filter.sv]
// synchroniser and glitch filter for one sync input
`timescale 1ns/100ps
`include "hv_sync_regs.svh"
module sync_glitch_filter
  import hv_sync_pkg::*;
(
  // clock and reset
  input  wire logic     clk,
  input  wire logic     sys_rst,
  // filtered signal
  sync_filter_if.filter port_f
);
  logic       meta_reg;
  logic       sync_reg;
  logic       clean_reg;
  logic [1:0] run_reg;
  wire        differs = sync_reg != clean_reg;
  wire        settled = run_reg == 2'(`GLITCH_CYCLES);
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= port_f.raw;
      sync_reg <= meta_reg;
    end
  end
  // level must hold a full glitch time before it is accepted
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      clean_reg <= 1'b0;
      run_reg   <= 2'h0;
    end else if (!differs) begin
      run_reg <= 2'h0;
    end else if (settled) begin
      clean_reg <= sync_reg;
      run_reg   <= 2'h0;
    end else begin
      run_reg <= run_reg + 2'h1;
    end
  end
  assign port_f.clean = clean_reg;
  assign port_f.rise  = differs && settled && sync_reg;
  assign port_f.fall  = differs && settled && !sync_reg;
endmodule : sync_glitch_filter

// [hdl/hv_sync_processor.sv]
// sync processor: counters, polarity, separator, insertion, free run, half frequency
//
// Summary of operation
// - sync pulses shorter than 125 ns are glitches and are dropped
// - count 8 us ticks between vertical pulses; latch 14-bit period, restart
// - vertical count overflow sets sticky flag, cleared by writing one
// - interval disable high: count horizontal pulses per frame, latch on vertical
// - interval disable low: count over 16.384 or 32.768 ms window
// - horizontal overflow sticky flag cleared by writing one; counter untouched
// - polarity of horizontal and vertical inputs from periodic level sampling; one means positive
// - presence bits show whether the horizontal and vertical sync inputs are active
// - output polarity bits choose sync output polarity
// - separate/composite bit zero turns on the composite sync separator
// - insertion disable low inserts 2 us pulses at last horizontal spacing
// - extracted vertical pulse output promptly and widened about 9 us
// - reset sets separate and insertion disable high, clears count latches
// - clearing an output enable turns the shared pin into that sync output
// - half enable low: half output at half input frequency, 50% duty
// - no-divide low: half output follows input with chosen polarity
// - reset holds half enable, no-divide and polarity high
// - free run select ignored unless a sync output is enabled
// - codes 000 and 001 give clock/256 and clock/180, vertical /512
// - codes 010, 011, 10x give /128 /840, /100 /1024, /88 /1024; 11x off
// - with free run, pattern enable low drives pin 14 with chosen pattern
// - half input on pin 13, half output on pin 12 when enabled
//
// Local design decisions: the register offsets and register access over Avalon-MM.
`timescale 1ns/100ps
`include "hv_sync_regs.svh"
module hv_sync_processor
  import hv_sync_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // avalon-mm slave
  input  wire logic [3:0] avs_address,
  input  wire logic       avs_read,
  input  wire logic       avs_write,
  input  wire logic [7:0] avs_writedata,
  output logic      [7:0] avs_readdata,
  output logic            avs_waitrequest,
  // sync inputs
  input  wire logic       horiz_sync_input,
  input  wire logic       vert_sync_input,
  input  wire logic       half_freq_input,
  // shared port pins
  output logic            horiz_sync_output,
  output logic            horiz_sync_output_oe,
  output logic            vert_sync_output,
  output logic            vert_sync_output_oe,
  output logic            half_freq_output,
  output logic            half_freq_output_oe,
  output logic            pattern_output,
  output logic            pattern_output_oe
);
  sync_filter_if h_if ();
  sync_filter_if v_if ();
  sync_filter_if f_if ();
  assign h_if.raw = horiz_sync_input;
  assign v_if.raw = vert_sync_input;
  assign f_if.raw = half_freq_input;
  sync_glitch_filter u_hf (.clk(clk), .sys_rst(sys_rst), .port_f(h_if.filter));
  sync_glitch_filter u_vf (.clk(clk), .sys_rst(sys_rst), .port_f(v_if.filter));
  sync_glitch_filter u_ff (.clk(clk), .sys_rst(sys_rst), .port_f(f_if.filter));

  function automatic logic active_edge(input logic pos, input logic r, input logic f);
    active_edge = pos ? r : f;
  endfunction : active_edge

  // control registers
  logic [7:0] sync_input_control_reg;
  logic [7:0] sync_io_control_reg;
  logic [7:0] free_run_control_reg;
  logic [7:0] half_freq_control_reg;
  wire  separate_mode            = sync_input_control_reg[0];
  wire  interval_select          = sync_input_control_reg[1];
  wire  interval_select_disable  = sync_input_control_reg[2];
  wire  insertion_disable        = sync_input_control_reg[3];
  wire  vert_output_polarity     = sync_io_control_reg[0];
  wire  horiz_output_polarity    = sync_io_control_reg[1];
  wire  vert_output_enable_n     = sync_io_control_reg[6];
  wire  horiz_output_enable_n    = sync_io_control_reg[7];
  wire  [2:0] free_run_select    = free_run_control_reg[2:0];
  wire  pattern_select           = free_run_control_reg[6];
  wire  pattern_enable_n         = free_run_control_reg[7];
  wire  half_output_polarity     = half_freq_control_reg[5];
  wire  half_bypass_n            = half_freq_control_reg[6];
  wire  half_freq_enable_n       = half_freq_control_reg[7];

  // bus decode
  wire wr_sic  = avs_write && avs_address == `SYNC_INPUT_CONTROL_ADDR;
  wire wr_sio  = avs_write && avs_address == `SYNC_IO_CONTROL_ADDR;
  wire wr_hhi  = avs_write && avs_address == `HCOUNT_HI_ADDR;
  wire wr_vhi  = avs_write && avs_address == `VCOUNT_HI_ADDR;
  wire wr_frc  = avs_write && avs_address == `FREE_RUN_CONTROL_ADDR;
  wire wr_hfc  = avs_write && avs_address == `HALF_FREQ_CONTROL_ADDR;
  wire free_run_allowed = !(vert_output_enable_n && horiz_output_enable_n);
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync_input_control_reg <= `CTRL_RESET;
      sync_io_control_reg    <= `CTRL_RESET;
      free_run_control_reg   <= `CTRL_RESET;
      half_freq_control_reg  <= `CTRL_RESET;
    end else begin
      if (wr_sic)
        sync_input_control_reg <= {4'hF, avs_writedata[3:0]};
      if (wr_sio)
        sync_io_control_reg <= {avs_writedata[7:6], 4'hF, avs_writedata[1:0]};
      if (wr_frc) begin
        free_run_control_reg[2:0] <= avs_writedata[2:0];
        if (free_run_allowed && free_run_control_reg[2:1] != 2'h3)
          free_run_control_reg[7:6] <= avs_writedata[7:6];
      end
      if (wr_hfc)
        half_freq_control_reg <= {avs_writedata[7:5], 5'h1F};
    end
  end

  // 8 us tick and window timing
  logic [5:0]  tick_div_reg;
  logic [11:0] win_reg;
  wire tick = tick_div_reg == 6'(`TICK_CYCLES - 1);
  wire win_end = tick && win_reg == (interval_select ? 12'hFFF : 12'(`WIN0_TICKS - 1));
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_div_reg <= 6'h0;
      win_reg      <= 12'h0;
    end else begin
      tick_div_reg <= tick ? 6'h0 : tick_div_reg + 6'h1;
      if (win_end)
        win_reg <= 12'h0;
      else if (tick)
        win_reg <= win_reg + 12'h1;
    end
  end

  // separator: composite sync carries vertical as a long pulse
  wire h_pos   = h_if.clean ? 1'b1 : 1'b0;
  logic h_pol_reg;
  logic v_pol_reg;
  wire h_act   = h_if.clean == h_pol_reg;
  wire h_lead  = active_edge(h_pol_reg, h_if.rise, h_if.fall);
  wire h_trail = active_edge(h_pol_reg, h_if.fall, h_if.rise);
  logic [4:0]  hwidth_reg;
  logic        csep_v_reg;
  logic [6:0]  widen_reg;
  wire long_h  = h_act && hwidth_reg == 5'h1F;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hwidth_reg <= 5'h0;
      csep_v_reg <= 1'b0;
      widen_reg  <= 7'h0;
    end else begin
      hwidth_reg <= !h_act ? 5'h0 : (long_h ? hwidth_reg : hwidth_reg + 5'h1);
      if (separate_mode) begin
        csep_v_reg <= 1'b0;
      end else if (long_h) begin
        csep_v_reg <= 1'b1;
        widen_reg  <= 7'(`VWIDEN_CYCLES);
      end else if (widen_reg != 7'h0) begin
        widen_reg  <= widen_reg - 7'h1;
      end else begin
        csep_v_reg <= 1'b0;
      end
    end
  end
  wire v_act  = separate_mode ? (v_if.clean == v_pol_reg) : csep_v_reg;
  logic v_act_d_reg;
  wire v_edge = v_act && !v_act_d_reg;

  // horizontal insertion inside vertical area
  logic [11:0] hspace_reg;
  logic [11:0] hgap_reg;
  logic [11:0] ins_cnt_reg;
  wire ins_mode = !separate_mode && !insertion_disable && csep_v_reg;
  wire ins_fire = ins_mode && ins_cnt_reg == hspace_reg;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      v_act_d_reg <= 1'b0;
      hspace_reg  <= 12'hFFF;
      hgap_reg    <= 12'h0;
      ins_cnt_reg <= 12'h0;
    end else begin
      v_act_d_reg <= v_act;
      hgap_reg    <= h_lead ? 12'h0 : (hgap_reg == 12'hFFF ? hgap_reg : hgap_reg + 12'h1);
      if (h_lead && !csep_v_reg)
        hspace_reg <= hgap_reg;
      if (!ins_mode || ins_fire)
        ins_cnt_reg <= ins_mode ? 12'h1 : hgap_reg + 12'h1;
      else
        ins_cnt_reg <= ins_cnt_reg + 12'h1;
    end
  end
  logic [4:0] ins_w_reg;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      ins_w_reg <= 5'h0;
    else if (ins_fire)
      ins_w_reg <= 5'(`INSERT_CYCLES);
    else if (ins_w_reg != 5'h0)
      ins_w_reg <= ins_w_reg - 5'h1;
  end
  wire h_out_act = ins_mode ? (ins_w_reg != 5'h0) : (h_act && !long_h);
  wire h_count_ev = ins_mode ? ins_fire : h_trail;

  // period and pulse counters
  logic [13:0] vcnt_reg;
  logic [13:0] vert_period_count_reg;
  logic        vert_count_overflow_reg;
  logic [11:0] hcnt_reg;
  logic [11:0] horiz_pulse_count_reg;
  logic        horiz_count_overflow_reg;
  wire v_ovf = tick && vcnt_reg == 14'h3FFF;
  wire h_ovf = h_count_ev && hcnt_reg == 12'hFFF;
  wire h_latch = interval_select_disable ? v_edge : win_end;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      vcnt_reg                 <= 14'h0;
      vert_period_count_reg    <= 14'h0;
      vert_count_overflow_reg  <= 1'b0;
      hcnt_reg                 <= 12'h0;
      horiz_pulse_count_reg    <= 12'h0;
      horiz_count_overflow_reg <= 1'b0;
    end else begin
      if (v_edge) begin
        vert_period_count_reg <= vcnt_reg;
        vcnt_reg              <= 14'h0;
      end else if (tick && !v_ovf) begin
        vcnt_reg <= vcnt_reg + 14'h1;
      end
      if (v_ovf)
        vert_count_overflow_reg <= 1'b1;
      else if (wr_vhi && avs_writedata[`OVF_CLEAR_BIT])
        vert_count_overflow_reg <= 1'b0;
      if (h_latch) begin
        horiz_pulse_count_reg <= hcnt_reg;
        hcnt_reg              <= 12'h0;
      end else if (h_count_ev && !h_ovf) begin
        hcnt_reg <= hcnt_reg + 12'h1;
      end
      if (h_ovf)
        horiz_count_overflow_reg <= 1'b1;
      else if (wr_hhi && avs_writedata[`OVF_CLEAR_BIT])
        horiz_count_overflow_reg <= 1'b0;
    end
  end

  // polarity and presence by periodic sampling
  logic [11:0] samp_reg;
  logic [12:0] h_hi_reg;
  logic [12:0] v_hi_reg;
  logic        h_seen_reg;
  logic        v_seen_reg;
  logic        h_present_reg;
  logic        v_present_reg;
  wire samp_end = samp_reg == 12'(`SAMPLE_CYCLES - 1);
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      samp_reg <= 12'h0;
      h_hi_reg <= 13'h0;
      v_hi_reg <= 13'h0;
      h_pol_reg <= 1'b1;
      v_pol_reg <= 1'b1;
      h_seen_reg <= 1'b0;
      v_seen_reg <= 1'b0;
      h_present_reg <= 1'b0;
      v_present_reg <= 1'b0;
    end else begin
      samp_reg <= samp_reg + 12'h1;
      if (samp_end) begin
        h_pol_reg <= h_hi_reg < 13'h0800;
        v_pol_reg <= v_hi_reg < 13'h0800;
        h_hi_reg  <= 13'h0;
        v_hi_reg  <= 13'h0;
      end else begin
        h_hi_reg <= h_hi_reg + {12'h0, h_pos};
        v_hi_reg <= v_hi_reg + {12'h0, v_if.clean};
      end
      if (v_edge) begin
        h_present_reg <= h_seen_reg;
        v_present_reg <= 1'b1;
        h_seen_reg    <= 1'b0;
      end else if (h_lead) begin
        h_seen_reg <= 1'b1;
      end
      if (v_ovf)
        v_present_reg <= 1'b0;
      if (win_end && !h_seen_reg)
        h_present_reg <= 1'b0;
    end
  end

  // free run generator
  free_run_cfg_t cfg;
  always_comb begin
    cfg = '{h_div: 8'd255, h_pre: 4'd0, v_div: 11'd511, active: 1'b1};
    case (free_run_select)
      3'b001:  cfg = '{h_div: 8'd44, h_pre: 4'd3, v_div: 11'd511, active: 1'b1};
      3'b010:  cfg = '{h_div: 8'd127, h_pre: 4'd0, v_div: 11'd839, active: 1'b1};
      3'b011:  cfg = '{h_div: 8'd24, h_pre: 4'd3, v_div: 11'd1023, active: 1'b1};
      3'b100,
      3'b101:  cfg = '{h_div: 8'd21, h_pre: 4'd3, v_div: 11'd1023, active: 1'b1};
      3'b110,
      3'b111:  cfg.active = 1'b0;
      default: cfg = '{h_div: 8'd255, h_pre: 4'd0, v_div: 11'd511, active: 1'b1};
    endcase
  end
  wire free_run = cfg.active && free_run_allowed;
  logic [3:0]  fr_pre_reg;
  logic [7:0]  fr_h_reg;
  logic [10:0] fr_v_reg;
  free_run_state_t fr_state_reg;
  wire fr_pre_end = fr_pre_reg == cfg.h_pre;
  wire fr_h_end = fr_pre_end && fr_h_reg == cfg.h_div;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fr_pre_reg   <= 4'h0;
      fr_h_reg     <= 8'h0;
      fr_v_reg     <= 11'h0;
      fr_state_reg <= fr_idle;
    end else begin
      case (fr_state_reg)
        fr_idle: begin
          fr_pre_reg <= 4'h0;
          fr_h_reg   <= 8'h0;
          fr_v_reg   <= 11'h0;
          if (free_run)
            fr_state_reg <= fr_pulse;
        end
        fr_pulse,
        fr_gap: begin
          fr_pre_reg <= fr_pre_end ? 4'h0 : fr_pre_reg + 4'h1;
          if (fr_pre_end)
            fr_h_reg <= fr_h_end ? 8'h0 : fr_h_reg + 8'h1;
          if (fr_h_end)
            fr_v_reg <= fr_v_reg == cfg.v_div ? 11'h0 : fr_v_reg + 11'h1;
          if (!free_run)
            fr_state_reg <= fr_idle;
          else if (fr_h_end)
            fr_state_reg <= fr_pulse;
          else if (fr_h_reg[7:3] != 5'h0)
            fr_state_reg <= fr_gap;
        end
        default: fr_state_reg <= fr_idle;
      endcase
    end
  end
  wire fr_h_act = fr_state_reg == fr_pulse;
  wire fr_v_act = fr_state_reg != fr_idle && fr_v_reg < 11'd8;
  wire pat_video = fr_state_reg == fr_gap && fr_v_reg >= 11'd16 &&
                   (pattern_select ? fr_h_reg[4] ^ fr_v_reg[5] : 1'b1);

  // half frequency divider
  logic half_div_reg;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      half_div_reg <= 1'b0;
    else if (half_freq_enable_n)
      half_div_reg <= 1'b0;
    else if (f_if.rise)
      half_div_reg <= !half_div_reg;
  end

  // output pins registered from the selected sources
  wire h_src = free_run ? fr_h_act : h_out_act;
  wire v_src = free_run ? fr_v_act : v_act;
  wire half_src = half_bypass_n ? half_div_reg : (f_if.clean ~^ half_output_polarity);
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      horiz_sync_output <= 1'b0;
      vert_sync_output  <= 1'b0;
      half_freq_output  <= 1'b0;
      pattern_output    <= 1'b0;
    end else begin
      horiz_sync_output <= h_src ~^ horiz_output_polarity;
      vert_sync_output  <= v_src ~^ vert_output_polarity;
      half_freq_output  <= half_src;
      pattern_output    <= pat_video;
    end
  end
  assign horiz_sync_output_oe = !horiz_output_enable_n;
  assign vert_sync_output_oe  = !vert_output_enable_n;
  assign half_freq_output_oe  = !half_freq_enable_n;
  assign pattern_output_oe    = free_run && !pattern_enable_n;

  // read mux
  wire [7:0] rd_mux =
    avs_address == `SYNC_INPUT_CONTROL_ADDR ? {4'h0, sync_input_control_reg[3], 1'b0,
                                               sync_input_control_reg[1:0]} :
    avs_address == `SYNC_IO_CONTROL_ADDR ? {2'h0, h_present_reg, v_present_reg,
                                            h_pol_reg, v_pol_reg, sync_io_control_reg[1:0]} :
    avs_address == `HCOUNT_LO_ADDR ? horiz_pulse_count_reg[7:0] :
    avs_address == `HCOUNT_HI_ADDR ? {horiz_count_overflow_reg, 3'h0,
                                      horiz_pulse_count_reg[11:8]} :
    avs_address == `VCOUNT_LO_ADDR ? vert_period_count_reg[7:0] :
    avs_address == `VCOUNT_HI_ADDR ? {vert_count_overflow_reg, 1'b0,
                                      vert_period_count_reg[13:8]} :
    8'h00;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      avs_readdata <= 8'h00;
    else if (avs_read)
      avs_readdata <= rd_mux;
  end
  logic rd_done_reg;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      rd_done_reg <= 1'b0;
    else
      rd_done_reg <= avs_read && !rd_done_reg;
  end
  assign avs_waitrequest = avs_read && !rd_done_reg;
endmodule : hv_sync_processor

// [bench/hv_sync_props.sv]
// checker on the sync processor ports
`timescale 1ns/100ps
`include "hv_sync_regs.svh"
module hv_sync_props (
  // clock, reset and bus
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic [3:0] avs_address,
  input wire logic       avs_read,
  input wire logic       avs_write,
  input wire logic [7:0] avs_writedata,
  input wire logic [7:0] avs_readdata,
  input wire logic       avs_waitrequest,
  // pin enables
  input wire logic       horiz_sync_output_oe,
  input wire logic       vert_sync_output_oe,
  input wire logic       half_freq_output_oe,
  input wire logic       pattern_output_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [7:0] io_reg, fr_reg;
  logic       seen_reg;
  wire        io_wr  = avs_write && avs_address == `SYNC_IO_CONTROL_ADDR;
  wire        fr_wr  = avs_write && avs_address == `FREE_RUN_CONTROL_ADDR;
  wire        hf_wr  = avs_write && avs_address == `HALF_FREQ_CONTROL_ADDR;
  wire        fr_off = fr_reg[2:1] == 2'b11 || (io_reg[7] && io_reg[6]);
  // shadow of the control bits
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      io_reg   <= `CTRL_RESET;
      fr_reg   <= `CTRL_RESET;
      seen_reg <= 1'b0;
    end else begin
      if (io_wr) io_reg <= avs_writedata;
      if (fr_wr) fr_reg <= avs_writedata;
      if (avs_write) seen_reg <= 1'b1;
    end
  end
  read_wait_a: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("read answer late");
  write_nowait_a: assert property (avs_write |-> !avs_waitrequest)
    else $error("write waited");
  idle_pins_a: assert property (!seen_reg |-> !(horiz_sync_output_oe || vert_sync_output_oe ||
    half_freq_output_oe || pattern_output_oe)) else $error("pin enabled after reset");
  hout_enable_a: assert property (io_wr |=> horiz_sync_output_oe == !$past(avs_writedata[7]))
    else $error("horiz enable wrong");
  vout_enable_a: assert property (io_wr |=> vert_sync_output_oe == !$past(avs_writedata[6]))
    else $error("vert enable wrong");
  half_enable_a: assert property (hf_wr |=> half_freq_output_oe == !$past(avs_writedata[7]))
    else $error("half enable wrong");
  pattern_gate_a: assert property (fr_off |-> !pattern_output_oe)
    else $error("pattern without free run");
  rdata_stand_a: assert property (!avs_read && !$past(avs_read) |-> $stable(avs_readdata))
    else $error("read data moved");
  unmapped_zero_a: assert property (avs_read && !avs_waitrequest && avs_address < 4'h6
    |-> avs_readdata == 8'h00) else $error("unmapped read not zero");
  cover property (io_wr && !avs_writedata[7]);
  cover property ($rose(pattern_output_oe));
  cover property ($rose(half_freq_output_oe));
endmodule : hv_sync_props
bind hv_sync_processor hv_sync_props u_props (.*);

// [bench/sync_source_model.sv]
// video source: positive separate sync and a half frequency square
`timescale 1ns/100ps
module sync_source_model (
  // control
  input  wire logic        clk,
  input  wire logic        run,
  input  wire logic [15:0] h_per,
  input  wire logic [15:0] lines,
  // sync lines
  output logic             hs,
  output logic             vs,
  output logic             hf
);
  logic [15:0] hc = 16'h0000;
  logic [15:0] lc = 16'h0000;
  logic [5:0]  fc = 6'h00;
  initial {hs, vs, hf} = 3'b000;
  always @(posedge clk) begin
    hc <= (hc + 16'h0001 >= h_per) ? 16'h0000 : hc + 16'h0001;
    if (hc + 16'h0001 >= h_per) lc <= (lc + 16'h0001 >= lines) ? 16'h0000 : lc + 16'h0001;
    fc <= (fc == 6'h27) ? 6'h00 : fc + 6'h01;
    if (fc == 6'h27) hf <= ~hf;
    hs <= run && hc < 16'h0010;
    vs <= run && lc < 16'h0002;
  end
endmodule : sync_source_model

// [bench/tb_top.sv]
// self-checking bench for the sync processor
`timescale 1ns/100ps
`include "hv_sync_regs.svh"
module tb_top;
  logic        clk, sys_rst, avs_read, avs_write, run, hs, vs, hf, comp;
  logic        avs_waitrequest, ho, hoe, vo, voe, fo, foe, po, poe;
  logic [3:0]  avs_address;
  logic [7:0]  avs_writedata, avs_readdata, rd;
  logic [15:0] h_per, lines;
  integer      failures, samples_checked, seed, n, i, t0, t1, fo_n;
  integer      cyc_n = 0;
  integer      per [6] = '{256, 180, 128, 100, 88, 88};
  sync_source_model u_src (.clk(clk), .run(run), .h_per(h_per), .lines(lines),
    .hs(hs), .vs(vs), .hf(hf));
  hv_sync_processor u_dut (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .horiz_sync_input(hs | (vs & comp)), .vert_sync_input(vs), .half_freq_input(hf),
    .horiz_sync_output(ho), .horiz_sync_output_oe(hoe), .vert_sync_output(vo),
    .vert_sync_output_oe(voe), .half_freq_output(fo), .half_freq_output_oe(foe),
    .pattern_output(po), .pattern_output_oe(poe));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) cyc_n <= cyc_n + 1;
  always @(fo) fo_n = fo_n + 1;
  task automatic end_of_test();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  task automatic near(input string nm, input integer e, input integer tol, input logic [15:0] g);
    samples_checked++;
    if ((^g === 1'bx) || g > e + tol || g + tol < e) begin
      failures++;
      $display("CHECK FAILED %s expected %0d seen %0d", nm, e, g);
    end
  endtask : near
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rdr(input logic [3:0] a);
    avs_address <= a;
    avs_read    <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask : rdr
  task automatic edge_t(output integer t);
    integer k;
    for (k = 0; ho !== 1'b0 && k < 2000; k++) @(posedge clk);
    for (k = 0; ho !== 1'b1 && k < 2000; k++) @(posedge clk);
    t = cyc_n;
  endtask : edge_t
  initial begin
    #1000000;
    failures++;
    end_of_test();
  end
  initial begin
    seed = 32'h3489;
    {failures, samples_checked, fo_n} = 0;
    {sys_rst, avs_read, avs_write, avs_address, avs_writedata, run, comp} = 17'h10000;
    h_per = 16'h0064;
    lines = 16'h0014;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    for (i = 8; i < 12; i++) begin
      rdr(i[3:0]);
      chk("count latch", 16'h0000, rd);
    end
    wr(`VCOUNT_LO_ADDR, 8'h55);
    rdr(`VCOUNT_LO_ADDR);
    chk("ro count", 16'h0000, rd);
    rdr(4'h0);
    chk("unmapped", 16'h0000, rd);
    rdr(`SYNC_INPUT_CONTROL_ADDR);
    chk("input ctl", 16'h000B, rd & 8'h0B);
    rdr(`SYNC_IO_CONTROL_ADDR);
    chk("out pol", 16'h0003, rd & 8'h03);
    chk("pins idle", 16'h0000, {hoe, voe, foe, poe});
    run <= 1'b1;
    for (n = 0; n < 4; n++) begin
      comp <= (n == 3);
      wr(`SYNC_INPUT_CONTROL_ADDR, n == 3 ? 8'hFE : 8'hFF);
      if (n > 0) h_per <= 16'h0050 + 16'($random(seed) & 32'h3F);
      if (n > 0) lines <= 16'h0010 + 16'($random(seed) & 32'h0F);
      @(posedge clk);
      repeat (3 * h_per * lines + 200) @(posedge clk);
      rdr(`VCOUNT_LO_ADDR);
      t0 = rd;
      rdr(`VCOUNT_HI_ADDR);
      near("vert period", h_per * lines / 64, 1, {rd[5:0], t0[7:0]});
      chk("vert ovf", 16'h0000, rd[7]);
      rdr(`HCOUNT_LO_ADDR);
      t0 = rd;
      rdr(`HCOUNT_HI_ADDR);
      chk("horiz count", lines - (n == 3 ? 16'h0002 : 16'h0000), {rd[3:0], t0[7:0]});
    end
    rdr(`SYNC_IO_CONTROL_ADDR);
    chk("in status", 16'h003C, rd & 8'h3C);
    comp <= 1'b0;
    wr(`SYNC_INPUT_CONTROL_ADDR, 8'hFF);
    wr(`SYNC_IO_CONTROL_ADDR, 8'h02);
    chk("sync oe", 16'h0003, {hoe, voe});
    @(posedge hs);
    repeat (10) @(posedge clk);
    chk("h out on", 16'h0001, ho);
    repeat (40) @(posedge clk);
    chk("h out off", 16'h0000, ho);
    @(posedge vs);
    repeat (10) @(posedge clk);
    chk("v out on", 16'h0000, vo);
    repeat (3 * h_per) @(posedge clk);
    chk("v out off", 16'h0001, vo);
    wr(`HALF_FREQ_CONTROL_ADDR, 8'h40);
    chk("half oe", 16'h0001, foe);
    repeat (200) @(posedge clk);
    fo_n = 0;
    repeat (800) @(posedge clk);
    near("half toggles", 10, 1, fo_n);
    for (n = 0; n < 2; n++) begin
      wr(`HALF_FREQ_CONTROL_ADDR, n ? 8'h20 : 8'h00);
      @(posedge hf);
      repeat (20) @(posedge clk);
      chk("half follow", n, fo);
    end
    run <= 1'b0;
    wr(`SYNC_IO_CONTROL_ADDR, 8'hFF);
    wr(`FREE_RUN_CONTROL_ADDR, 8'h00);
    chk("pattern refused", 16'h0000, poe);
    wr(`SYNC_IO_CONTROL_ADDR, 8'h03);
    for (i = 0; i < 8; i++) begin
      wr(`FREE_RUN_CONTROL_ADDR, {1'b0, i[0], 3'b000, i[2:0]});
      wr(`FREE_RUN_CONTROL_ADDR, {1'b0, i[0], 3'b000, i[2:0]});
      chk("pattern oe", i < 6, poe);
      if (i < 6) begin
        for (n = 0; po !== 1'b1 && n < 5000; n++) @(posedge clk);
        chk("pattern on", 16'h0001, po);
        edge_t(t0);
        edge_t(t1);
        near("free run period", per[i], 1, t1 - t0);
      end
    end
    end_of_test();
  end
endmodule : tb_top
